//--- verilog/mrt_pkg.sv
// Constants and types for the multi-register transfer timing sequencer
package mrt_pkg;

   // Register file layout
   localparam int          NUM_REGS          = 16;
   localparam logic [3:0]  SP_IDX            = 4'hD;
   localparam logic [3:0]  PC_IDX            = 4'hF;

   // Memory datapath: two 32-bit words per beat
   localparam int          WORD_BITS         = 32;
   localparam int          BEAT_BYTES        = 8;
   localparam int          ALIGN_BIT         = 2;
   localparam logic [1:0]  LANES_BOTH        = 2'h3;
   localparam logic [1:0]  LANES_LOW         = 2'h1;
   localparam logic [1:0]  LANES_HIGH        = 2'h2;

   // Timing counts in core cycles
   localparam logic [3:0]  LOAD_LAT_BASE     = 4'h2;
   localparam logic [3:0]  RET_MISS_PENALTY  = 4'h8;
   localparam logic [3:0]  COND_MISS_PENALTY = 4'h7;
   localparam logic [4:0]  EXC_RET_ALIGNED   = 5'h0A;
   localparam logic [4:0]  EXC_RET_UNALIGNED = 5'h0B;
   localparam logic [4:0]  EXC_SAVE_ALIGNED  = 5'h01;
   localparam logic [4:0]  EXC_SAVE_UNALIGNED= 5'h02;
   localparam logic [4:0]  EXC_WORDS         = 5'h02;

   // Return stack
   localparam int          RET_DEPTH         = 4;
   localparam logic [2:0]  RET_FULL          = 3'h4;

   // Transfer kinds
   typedef enum logic [2:0] {
      KIND_MULTI_LOAD  = 3'b000,
      KIND_MULTI_STORE = 3'b001,
      KIND_POP         = 3'b010,
      KIND_PUSH        = 3'b011,
      KIND_EXC_RETURN  = 3'b100,
      KIND_EXC_SAVE    = 3'b101
   } xfer_kind_t;

   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_ISSUE   = 2'b01,
      ST_CHECK   = 2'b10,
      ST_PENALTY = 2'b11
   } seq_state_t;

endpackage

//--- verilog/multi_xfer_timer.sv
// Issue, memory-beat, latency and return-prediction timing for block transfers
`timescale 1ns/1ns

// Notes on behaviour
// - Two registers move per memory beat over the 64-bit data path.
// - Base register is read at the very start, the accept cycle.
// - Aligned load of N: ceil(N/2) cycles, floor(N/2)+1 with write-back.
// - Unaligned load: ceil((N+1)/2) cycles, floor((N+1)/2)+1 with write-back.
// - Loaded latencies rise in pairs, offset by one when unaligned.
// - Push and pop use the stack pointer and always write back.
// - Four-entry return stack predicts loads of program counter without status.
// - Program counter load costs m, or m+8 on wrong return prediction.
// - Conditional program counter load costs m+7 on condition mispredict.
// - Conditional load costs m if both right, m+8 if return wrong.
// - Use of last register of aligned seven-load interlocks, six cycles.
// - Seven-store then independent instruction takes five cycles.
// - Early register use hides behind remaining issue cycles.
// - Nine-register aligned pop then use of ninth takes seven cycles.
// - Seven-register push then reading a pushed register takes five.
// - Exception return and save use one beat aligned, two otherwise.
// - Exception return takes 10 cycles aligned, 11 unaligned.
// - Exception state save takes 1 cycle aligned, 2 unaligned.
module multi_xfer_timer
   import mrt_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   input  wire logic        reqValid,
   input  wire xfer_kind_t  reqKind,
   input  wire logic [15:0] reqRegList,
   input  wire logic [3:0]  reqBaseReg,
   input  wire logic        reqWriteBack,
   input  wire logic [31:0] reqFirstAddr,
   input  wire logic        reqRestoreStatus,
   input  wire logic        reqCondMispredict,
   output logic             reqReady,
   output logic             baseReadValid,
   output logic [3:0]       baseReadReg,
   input  wire logic        callValid,
   input  wire logic [31:0] callReturnAddr,
   output logic             memValid,
   output logic             memWrite,
   output logic [31:0]      memAddr,
   output logic [1:0]       memLanes,
   input  wire logic [63:0] memRdData,
   input  wire logic        depValid,
   input  wire logic [3:0]  depReg,
   output logic             depStall
);

   ////////////////////////////////////////////////////////////////////////
   // Shared arithmetic

   // Number of registers in a list
   function automatic logic [4:0] countRegs(input logic [15:0] list);
      logic [4:0] c;
      c = 5'h00;
      for (int i = 0; i < NUM_REGS; i++) begin
         c = c + {4'h0, list[i]};
      end
      return c;
   endfunction

   // Cycles for a block transfer; also beats when write-back is off
   function automatic logic [4:0] blockCycles(input logic [4:0] n,
                                              input logic       unal,
                                              input logic       wb);
      logic [4:0] t;
      t = n + {4'h0, unal};
      return wb ? (t >> 1) + 5'h01 : (t + 5'h01) >> 1;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Request decode

   seq_state_t  state;
   logic [4:0]  remain;
   logic [4:0]  wordsLeft;
   logic [3:0]  penCnt;
   logic        pcPending;
   logic        pcSeen;
   logic [31:0] pcLatched;
   logic        pcLane;
   logic        condMiss;
   logic        predRet;
   logic        rsHit;
   logic [31:0] predTarget;
   logic [31:0] retStack [RET_DEPTH];
   logic [2:0]  rsCount;
   logic [3:0]  sb [NUM_REGS];

   logic        accept;
   logic        isLoad;
   logic        isExc;
   logic        isStack;
   logic        wbEff;
   logic        unal;
   logic        hasPc;
   logic [4:0]  nRegs;
   logic [4:0]  nWords;
   logic [4:0]  cycles;
   logic [3:0]  penNow;
   logic [31:0] pcWordNow;
   logic [3:0]  lat [NUM_REGS];
   logic [4:0]  k;

   // Kind, alignment and cycle count of the offered request
   always_comb begin
      isStack = (reqKind == KIND_POP) || (reqKind == KIND_PUSH);
      isExc   = (reqKind == KIND_EXC_RETURN) || (reqKind == KIND_EXC_SAVE);
      isLoad  = (reqKind == KIND_MULTI_LOAD) || (reqKind == KIND_POP) ||
                (reqKind == KIND_EXC_RETURN);
      wbEff   = reqWriteBack || isStack;
      unal    = reqFirstAddr[ALIGN_BIT];
      nRegs   = countRegs(reqRegList);
      nWords  = isExc ? EXC_WORDS : nRegs;
      hasPc   = reqRegList[PC_IDX] && isLoad && !isExc;
      if (reqKind == KIND_EXC_RETURN) begin
         cycles = unal ? EXC_RET_UNALIGNED : EXC_RET_ALIGNED;
      end else if (reqKind == KIND_EXC_SAVE) begin
         cycles = unal ? EXC_SAVE_UNALIGNED : EXC_SAVE_ALIGNED;
      end else begin
         cycles = blockCycles(nRegs, unal, wbEff);
      end
   end

   // Result latency per register, in list order, paired by beat
   always_comb begin
      k = 5'h00;
      for (int i = 0; i < NUM_REGS; i++) begin
         lat[i] = 4'h0;
         if (reqRegList[i] && isLoad && !isExc) begin
            lat[i] = LOAD_LAT_BASE + 4'((k + {4'h0, unal}) >> 1);
            k = k + 5'h01;
         end
      end
      if (wbEff) begin
         lat[baseReadReg] = cycles[3:0];
      end
   end

   // Base register is a very early operand, read as the request is taken
   assign accept        = reqValid && reqReady;
   assign baseReadValid = accept;
   assign baseReadReg   = isStack ? SP_IDX : reqBaseReg;

   ////////////////////////////////////////////////////////////////////////
   // Issue sequencing

   // Program counter word arrives in the last beat; pick it up live
   assign pcWordNow = pcSeen ? pcLatched :
                      (pcLane ? memRdData[63:32] : memRdData[31:0]);

   // Penalty once the loaded target is known
   always_comb begin
      if (condMiss) begin
         penNow = COND_MISS_PENALTY;
      end else if (predRet && rsHit && pcWordNow == predTarget) begin
         penNow = 4'h0;
      end else begin
         penNow = RET_MISS_PENALTY;
      end
   end

   // Ready in idle, or in the check cycle when nothing was mispredicted
   assign reqReady = (state == ST_IDLE) ||
                     (state == ST_CHECK && penNow == 4'h0);

   // Main sequencer; the check cycle is cycle m of a target load
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state  <= ST_IDLE;
         remain <= 5'h00;
         penCnt <= 4'h0;
      end else begin
         case (state)
            ST_IDLE, ST_CHECK: begin
               if (state == ST_CHECK && penNow != 4'h0) begin
                  state  <= ST_PENALTY;
                  penCnt <= penNow - 4'h1;
               end else if (accept) begin
                  remain <= cycles - 5'h01;
                  if (cycles != 5'h01) begin
                     state <= ST_ISSUE;
                  end else begin
                     state <= hasPc ? ST_CHECK : ST_IDLE;
                  end
               end else begin
                  state <= ST_IDLE;
               end
            end
            ST_ISSUE: begin
               remain <= remain - 5'h01;
               if (remain == 5'h01) begin
                  state <= pcPending ? ST_CHECK : ST_IDLE;
               end
            end
            ST_PENALTY: begin
               penCnt <= penCnt - 4'h1;
               if (penCnt == 4'h1) begin
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Memory beats

   // First beat follows the accept; unaligned start moves one high word
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         memValid  <= 1'b0;
         memWrite  <= 1'b0;
         memAddr   <= 32'h00000000;
         memLanes  <= 2'h0;
         wordsLeft <= 5'h00;
      end else if (accept) begin
         memValid <= 1'b1;
         memWrite <= !isLoad;
         memAddr  <= {reqFirstAddr[31:3], 3'h0};
         if (unal) begin
            memLanes  <= LANES_HIGH;
            wordsLeft <= nWords - 5'h01;
         end else if (nWords >= 5'h02) begin
            memLanes  <= LANES_BOTH;
            wordsLeft <= nWords - 5'h02;
         end else begin
            memLanes  <= LANES_LOW;
            wordsLeft <= 5'h00;
         end
      end else if (wordsLeft != 5'h00) begin
         memAddr <= memAddr + 32'(BEAT_BYTES);
         if (wordsLeft >= 5'h02) begin
            memLanes  <= LANES_BOTH;
            wordsLeft <= wordsLeft - 5'h02;
         end else begin
            memLanes  <= LANES_LOW;
            wordsLeft <= 5'h00;
         end
      end else begin
         memValid <= 1'b0;
         memLanes <= 2'h0;
      end
   end

   // Capture of the loaded target so a late check can still use it
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pcPending <= 1'b0;
         pcSeen    <= 1'b0;
         pcLatched <= 32'h00000000;
         pcLane    <= 1'b0;
         condMiss  <= 1'b0;
      end else if (accept) begin
         pcPending <= hasPc;
         pcSeen    <= 1'b0;
         pcLane    <= unal ^ nRegs[0] ^ 1'b1;
         condMiss  <= hasPc && reqCondMispredict;
      end else if (memValid && pcPending && wordsLeft == 5'h00 &&
                   !pcSeen) begin
         pcSeen    <= 1'b1;
         pcLatched <= pcWordNow;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Return stack

   // Calls push; a predicted return pops the top; both at once replace it
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rsCount    <= 3'h0;
         predRet    <= 1'b0;
         rsHit      <= 1'b0;
         predTarget <= 32'h00000000;
         for (int i = 0; i < RET_DEPTH; i++) begin
            retStack[i] <= 32'h00000000;
         end
      end else begin
         if (accept) begin
            predRet    <= hasPc && !reqRestoreStatus;
            rsHit      <= rsCount != 3'h0;
            predTarget <= retStack[0];
         end
         if (accept && hasPc && !reqRestoreStatus && rsCount != 3'h0) begin
            if (callValid) begin
               retStack[0] <= callReturnAddr;
            end else begin
               for (int i = 0; i < RET_DEPTH - 1; i++) begin
                  retStack[i] <= retStack[i + 1];
               end
               rsCount <= rsCount - 3'h1;
            end
         end else if (callValid) begin
            // Oldest entry is lost when full, which only costs a miss
            retStack[0] <= callReturnAddr;
            for (int i = 1; i < RET_DEPTH; i++) begin
               retStack[i] <= retStack[i - 1];
            end
            if (rsCount != RET_FULL) begin
               rsCount <= rsCount + 3'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Result scoreboard and interlock

   // Cycles until each register may be consumed
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            sb[i] <= 4'h0;
         end
      end else begin
         for (int i = 0; i < NUM_REGS; i++) begin
            if (accept && lat[i] != 4'h0) begin
               sb[i] <= lat[i] - 4'h1;
            end else if (sb[i] != 4'h0) begin
               sb[i] <= sb[i] - 4'h1;
            end
         end
      end
   end

   // Stores leave data registers free, so only issue slots can stall
   assign depStall = depValid && (!reqReady || sb[depReg] != 4'h0);

   ////////////////////////////////////////////////////////////////////////
   // Checks

   chk_pair_beats: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      accept && !isExc && !unal && nRegs == 5'h04
      |=> memLanes == LANES_BOTH ##1 memLanes == LANES_BOTH ##1 !memValid)
      else $error("four aligned words did not move as two pairs");

   chk_base_early: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      reqValid && reqReady |-> baseReadValid)
      else $error("base register not read at accept");

   chk_stack_base: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      baseReadValid && (reqKind == KIND_POP || reqKind == KIND_PUSH)
      |-> baseReadReg == SP_IDX && lat[SP_IDX] == cycles[3:0])
      else $error("stack transfer not based on stack pointer");

   chk_aligned_load: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      accept && reqKind == KIND_MULTI_LOAD && !unal && !reqWriteBack &&
      reqRegList == 16'h001E
      |=> !reqReady ##1 reqReady)
      else $error("aligned four-register load not two cycles");

   chk_unal_load_wb: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      accept && reqKind == KIND_MULTI_LOAD && unal && reqWriteBack &&
      reqRegList == 16'h001E
      |=> !reqReady [*2] ##1 reqReady)
      else $error("unaligned four-register load with write-back not three");

   chk_last_interlock: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      accept && reqKind == KIND_MULTI_LOAD && !unal && !reqWriteBack &&
      reqRegList == 16'h00FE
      |=> sb[7] == 4'h4 ##2 sb[3] == 4'h0 ##2 sb[7] == 4'h0)
      else $error("seven-load latencies wrong");

   chk_pop_nine: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      accept && reqKind == KIND_POP && !unal && reqRegList == 16'h03FE
      |=> !reqReady [*4] ##1 (reqReady && sb[9] == 4'h1))
      else $error("nine-register pop timing wrong");

   chk_push_seven: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      accept && reqKind == KIND_PUSH && !unal && reqRegList == 16'h00FE
      |=> (!reqReady && sb[7] == 4'h0) [*3] ##1 reqReady)
      else $error("seven-register push timing wrong");

   chk_ret_pop: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      accept && hasPc && !reqRestoreStatus && !callValid &&
      rsCount != 3'h0
      |=> rsCount == $past(rsCount) - 3'h1 && predRet)
      else $error("predicted return did not pop return stack");

   chk_ret_penalty: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      state == ST_CHECK && penNow == RET_MISS_PENALTY
      |=> !reqReady [*7] ##1 reqReady)
      else $error("return mispredict not eight cycles");

   chk_cond_penalty: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      state == ST_CHECK && condMiss
      |=> !reqReady [*6] ##1 reqReady)
      else $error("condition mispredict not seven cycles");

   chk_exc_return: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      accept && reqKind == KIND_EXC_RETURN && !unal
      |=> memValid ##1 !memValid ##0 !reqReady [*8] ##1 reqReady)
      else $error("aligned exception return timing wrong");

   chk_exc_save: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      accept && reqKind == KIND_EXC_SAVE && unal
      |=> !reqReady && memLanes == LANES_HIGH ##1
          reqReady && memLanes == LANES_LOW)
      else $error("unaligned exception save timing wrong");

   chk_unal_first: assert property (
      @(posedge sys_clk) disable iff (!rst_b)
      accept && unal && nWords >= 5'h03
      |=> memLanes == LANES_HIGH ##1 memLanes == LANES_BOTH)
      else $error("unaligned start did not send single word first");

endmodule // multi_xfer_timer

//--- sim/mem_model.sv
// Data memory model answering block-transfer beats over a 64-bit path
`timescale 1ns/1ns
module mem_model (
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   input  wire logic        memValid,
   input  wire logic        memWrite,
   input  wire logic [31:0] memAddr,
   output logic      [63:0] memRdData
);
   logic [63:0] noise;

   ////////////////////////////////////////////////////////////////////////
   // Idle pattern moves every cycle so stale read data never looks valid
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b)
         noise <= 64'hA5A5_0F0F_5A5A_F0F0;
      else
         noise <= {noise[62:0], ~noise[63]};
   end

   // Each word reads back as its own byte address, both words in the beat
   always_comb begin
      if (memValid && !memWrite)
         memRdData = {memAddr + 32'h4, memAddr};
      else
         memRdData = noise;
   end
endmodule // mem_model

//--- sim/tb_top.sv
// Self-checking bench for the block-transfer timing sequencer
`timescale 1ns/1ns
`define CHK(got, exp) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) begin \
         errors++; \
         $display("CHECK FAILED t=%0t value %0h exp %0h", $time, got, exp); \
      end \
   end
module tb_top;
   import mrt_pkg::*;
   logic        sys_clk, rst_b, reqValid, reqWriteBack, reqRestoreStatus;
   logic        reqCondMispredict, callValid, depValid, depStall;
   logic        reqReady, baseReadValid, memValid, memWrite;
   xfer_kind_t  reqKind;
   logic [15:0] reqRegList;
   logic [3:0]  reqBaseReg, baseReadReg, depReg;
   logic [31:0] reqFirstAddr, callReturnAddr, memAddr;
   logic [1:0]  memLanes;
   logic [63:0] memRdData;
   int          errors, cmp_count, seed, i;
   logic [31:0] r;

   multi_xfer_timer dut (.sys_clk(sys_clk), .rst_b(rst_b),
      .reqValid(reqValid), .reqKind(reqKind), .reqRegList(reqRegList),
      .reqBaseReg(reqBaseReg), .reqWriteBack(reqWriteBack),
      .reqFirstAddr(reqFirstAddr), .reqRestoreStatus(reqRestoreStatus),
      .reqCondMispredict(reqCondMispredict), .reqReady(reqReady),
      .baseReadValid(baseReadValid), .baseReadReg(baseReadReg),
      .callValid(callValid), .callReturnAddr(callReturnAddr),
      .memValid(memValid), .memWrite(memWrite), .memAddr(memAddr),
      .memLanes(memLanes), .memRdData(memRdData), .depValid(depValid),
      .depReg(depReg), .depStall(depStall));
   mem_model mem (.sys_clk(sys_clk), .rst_b(rst_b), .memValid(memValid),
      .memWrite(memWrite), .memAddr(memAddr), .memRdData(memRdData));

   ////////////////////////////////////////////////////////////////////////
   // Expected busy cycles; stores share the load formula
   function automatic int expCycles(xfer_kind_t k, logic [15:0] l, int u,
                                    logic wb, int pen);
      int w;
      w = $countones(l) + u;
      if (k == KIND_EXC_RETURN)
         return u ? int'(EXC_RET_UNALIGNED) : int'(EXC_RET_ALIGNED);
      if (k == KIND_EXC_SAVE)
         return u ? int'(EXC_SAVE_UNALIGNED) : int'(EXC_SAVE_ALIGNED);
      if (wb || k == KIND_POP || k == KIND_PUSH)
         return w / 2 + 1 + pen;
      return (w + 1) / 2 + pen;
   endfunction

   // First cycle a dependent reader of register rd may issue
   function automatic int expFree(xfer_kind_t k, logic [15:0] l, int u,
                                  logic [3:0] b, logic wb, logic [3:0] rd,
                                  int c);
      int idx, lat;
      idx = 0;
      lat = 0;
      if (k == KIND_MULTI_LOAD || k == KIND_POP) begin
         for (int j = 0; j < 16; j++) begin
            if (l[j] && j == rd)
               lat = int'(LOAD_LAT_BASE) + (idx + u) / 2;
            idx += l[j];
         end
         if ((wb || k == KIND_POP) && rd == (k == KIND_POP ? SP_IDX : b))
            lat = c;
      end
      return lat > c ? lat : c;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // One transfer: offer, accept, then watch beats, ready and interlock
   task automatic runReq(input xfer_kind_t k, input logic [15:0] l,
      input logic [3:0] b, input logic wb, input logic [31:0] a,
      input logic rs, input logic cm, input int pen, input logic [3:0] dr);
      int u, n, c, rdyAt, freeAt, beat, cyc;
      u = a[2];
      n = (k >= KIND_EXC_RETURN) ? 2 : $countones(l);
      rdyAt = 0;
      freeAt = 0;
      beat = 0;
      cyc = expCycles(k, l, u, wb, pen);
      reqValid <= 1'b1;
      reqKind <= k;
      reqRegList <= l;
      reqBaseReg <= b;
      reqWriteBack <= wb;
      reqFirstAddr <= a;
      reqRestoreStatus <= rs;
      reqCondMispredict <= cm;
      #1;
      `CHK(baseReadValid, 1'b1)
      `CHK(baseReadReg, (k == KIND_POP || k == KIND_PUSH) ? SP_IDX : b)
      @(posedge sys_clk);
      reqValid <= 1'b0;
      depValid <= 1'b1;
      depReg <= dr;
      for (c = 1; c < 40 && freeAt == 0; c++) begin
         #1;
         if (memValid === 1'b1) begin
            `CHK(memLanes, {2*beat+1-u < n, 2*beat >= u && 2*beat-u < n})
            `CHK(memAddr, {a[31:3], 3'h0} + 32'(8 * beat))
            `CHK(memWrite, k[0])
            beat++;
         end
         if (rdyAt == 0 && reqReady === 1'b1)
            rdyAt = c;
         if (depStall === 1'b0)
            freeAt = c;
         @(posedge sys_clk);
      end
      depValid <= 1'b0;
      `CHK(beat, (n + u + 1) / 2)
      `CHK(rdyAt, cyc)
      `CHK(freeAt, expFree(k, l, u, b, wb, dr, cyc))
   endtask

   // Call pushes a return address for the prediction stack
   task automatic doCall(input logic [31:0] ra);
      @(posedge sys_clk);
      callValid <= 1'b1;
      callReturnAddr <= ra;
      @(posedge sys_clk);
      callValid <= 1'b0;
   endtask

   // Reset in mid-run also clears the return stack
   task automatic doReset;
      rst_b <= 1'b0;
      repeat (5) @(posedge sys_clk);
      #1;
      `CHK(reqReady, 1'b1)
      `CHK(memValid, 1'b0)
      @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
   endtask

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Clock at 25 MHz
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // Watchdog sized well past the expected run length
   initial begin
      repeat (20000) @(posedge sys_clk);
      errors++;
      print_verdict();
   end

   // Main sequence: corner cases, return stack, then random traffic
   initial begin
      {reqValid, reqWriteBack, reqRestoreStatus, reqCondMispredict} = 4'h0;
      {callValid, depValid, depReg, reqBaseReg} = 10'h000;
      reqKind = KIND_MULTI_LOAD;
      reqRegList = 16'h0000;
      reqFirstAddr = 32'h0000_0000;
      callReturnAddr = 32'h0000_0000;
      errors = 0;
      cmp_count = 0;
      seed = 32'h2E20EA71;
      rst_b = 1'b0;
      repeat (5) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      runReq(KIND_MULTI_LOAD, 16'h00FE, 4'h0, 1'b0, 32'h100, 0, 0, 0, 4'h7);
      runReq(KIND_MULTI_STORE, 16'h00FE, 4'h0, 1'b0, 32'h100, 0, 0, 0, 4'h7);
      runReq(KIND_MULTI_LOAD, 16'h00FE, 4'h0, 1'b0, 32'h100, 0, 0, 0, 4'h3);
      runReq(KIND_POP, 16'h03FE, 4'h0, 1'b0, 32'h200, 0, 0, 0, 4'h9);
      runReq(KIND_PUSH, 16'h00FE, 4'h0, 1'b0, 32'h200, 0, 0, 0, 4'h7);
      runReq(KIND_MULTI_LOAD, 16'h00FE, 4'h0, 1'b1, 32'h104, 0, 0, 0, 4'h7);
      runReq(KIND_MULTI_LOAD, 16'h001E, 4'h0, 1'b0, 32'h100, 0, 0, 0, 4'h4);
      runReq(KIND_MULTI_LOAD, 16'h001E, 4'h0, 1'b1, 32'h104, 0, 0, 0, 4'h4);
      for (i = 0; i < 4; i++)
         runReq(xfer_kind_t'(3'h4 + i[0]), 16'h0, 4'h1, 1'b0,
                32'h300 + 32'(4 * i[1]), 0, 0, 0, 4'h2);
      $display("interlock and exception tests done");
      doCall(32'h1008);
      runReq(KIND_MULTI_LOAD, 16'h8030, 4'h2, 0, 32'h1000, 0, 0, 0, 4'h4);
      runReq(KIND_MULTI_LOAD, 16'h8030, 4'h2, 0, 32'h1000, 0, 0, 8, 4'h4);
      doCall(32'h2008);
      runReq(KIND_POP, 16'h8001, 4'h2, 1, 32'h2004, 0, 0, 0, 4'h0);
      doCall(32'h1008);
      runReq(KIND_MULTI_LOAD, 16'h8030, 4'h2, 0, 32'h1000, 1, 0, 8, 4'h5);
      runReq(KIND_MULTI_LOAD, 16'h8030, 4'h2, 0, 32'h1000, 0, 1, 7, 4'h5);
      doReset();
      doCall(32'h3000);
      runReq(KIND_MULTI_LOAD, 16'h8030, 4'h2, 0, 32'h1000, 0, 0, 8, 4'h5);
      doReset();
      // One call more than the stack holds, so the oldest is lost
      for (i = 0; i <= RET_DEPTH; i++)
         doCall(32'h1008 + 32'(16 * i));
      for (i = RET_DEPTH; i >= 0; i--)
         runReq(KIND_MULTI_LOAD, 16'h8030, 4'h2, 0, 32'h1000 + 32'(16 * i),
                0, 0, (i == 0) ? 8 : 0, 4'h4);
      $display("return stack tests done");
      for (i = 0; i < 150; i++) begin
         r = $random(seed);
         runReq(xfer_kind_t'(3'(r[18:16] % 3'h6)),
                (r[14:0] == 15'h0) ? 16'h0001 : {1'b0, r[14:0]},
                {1'b0, r[30:28]}, r[31], {20'h0, r[27:19], 3'h0} | {29'h0,
                r[15], 2'h0}, r[21], 1'b0, 0,
                (r[25:22] == 4'hF) ? 4'hE : r[25:22]);
      end
      $display("random tests done");
      print_verdict();
   end
endmodule // tb_top
